//--- rtl/fcd_map.svh
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
`define FCD_N_GLOBAL 32
`define FCD_N_DYN 8
`define FCD_DYN_PER_SIDE 2
`define FCD_DYN_INPUTS 4
`define FCD_DYN_SEL_W 2
`define FCD_N_CREG 4
`define FCD_REG_PER_HALF 4
`define FCD_REG_TB 8
`define FCD_N_LOCAL 16
`define FCD_REMOTE_CORE 16
`define FCD_REGION_ROWS 80
`define FCD_LOCAL_ROWS 40
`define FCD_TB_CLKS 16
`define FCD_TB_GLOBAL 14
`define FCD_TB_FABRIC 2
`define FCD_LR_CLKS 4
`define FCD_LR_FABRIC 2
`define FCD_PLL_OUTS 5
`define FCD_PLL_GLB_OUTS 4
`define FCD_PLL_OUT4 4
`define FCD_CTL_N 3
`define FCD_CTL_SEL_W 5
`define FCD_POOL_W 64
`define FCD_SEL_W 6
`endif

//--- rtl/fcd_pkg.sv
`include "fcd_map.svh"
package fcd_pkg;
  typedef logic [`FCD_POOL_W-1:0] fcd_pool_t;
  typedef logic [`FCD_SEL_W-1:0] fcd_sel_t;
  typedef enum logic [1:0] {
    FCD_MUX_RUN = 2'h0,
    FCD_MUX_DRAIN = 2'h1,
    FCD_MUX_ARM = 2'h3
  } fcd_mux_state_t;

  // every route picks one line of a padded source pool
  function automatic logic fcd_pick(input fcd_pool_t pool, input fcd_sel_t sel);
    return pool[sel];
  endfunction : fcd_pick
endpackage : fcd_pkg

//--- rtl/fcd_gate.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_gate import fcd_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic src,
  input wire logic en,
  output logic out_q
);
  logic en_q;

  // enable only moves while the source is low, so no high phase is cut
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (!src) begin
      en_q <= en; // see RULE2
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= src & en_q; // see RULE2
    end
  end

  AST_GATE_NO_RUNT: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
    $fell(out_q) |-> !$past(src)) else $error("gate output fell while source was high");
  AST_GATE_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
    (!src && !en) |-> ##2 !out_q) else $error("gate output high after disable");
  AST_GATE_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
    (en && !src) ##1 src |=> out_q) else $error("enabled gate did not pass source");
endmodule : fcd_gate
`default_nettype wire

//--- rtl/fcd_dynmux.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.svh"
module fcd_dynmux import fcd_pkg::*; #(
  parameter int N = `FCD_DYN_INPUTS,
  parameter int SW = `FCD_DYN_SEL_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [N-1:0] src,
  input wire logic [SW-1:0] sel,
  output logic out_q
);
  fcd_mux_state_t st_q;
  logic [SW-1:0] cur_q;
  logic cur_src;

  assign cur_src = src[cur_q];

  // old phase completes, output parks low, new source admitted only when low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= FCD_MUX_RUN;
      cur_q <= '0;
    end else begin
      case (st_q)
        FCD_MUX_RUN: begin
          if (sel != cur_q) begin
            st_q <= FCD_MUX_DRAIN; // see RULE4
          end
        end
        FCD_MUX_DRAIN: begin
          if (!cur_src) begin
            cur_q <= sel; // see RULE21
            st_q <= FCD_MUX_ARM;
          end
        end
        FCD_MUX_ARM: begin
          if (!cur_src) begin
            st_q <= FCD_MUX_RUN; // see RULE21
          end
        end
        default: begin
          st_q <= FCD_MUX_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= (st_q != FCD_MUX_ARM) & cur_src; // see RULE3
    end
  end

  AST_MUX_NO_RUNT: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE21
    $fell(out_q) |-> !$past(cur_src)) else $error("mux output fell mid phase");
  AST_MUX_ARM_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE21
    st_q == FCD_MUX_ARM |=> !out_q) else $error("mux output high while arming");
  AST_MUX_SETTLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE3
    (st_q == FCD_MUX_DRAIN && !cur_src) |=> (cur_q == $past(sel) && st_q == FCD_MUX_ARM))
    else $error("mux did not take new select");
endmodule : fcd_dynmux
`default_nettype wire

//--- rtl/fcd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.svh"
// Function
// RULE1 - thirty-two balanced global lines, each usable as clock or control
// RULE2 - every network has run-time enable gating that never glitches; here only global and regional lines are gated
// RULE3 - eight dynamic source muxes, two per fabric side
// RULE4 - user logic drives the select bus of each dynamic mux
// RULE5 - four core regional networks plus one each for top and bottom
// RULE6 - left and right halves of each region sourced independently
// RULE7 - global buffers drive global and regional lines from core or interface
// RULE8 - PLL outputs zero to three feed the global network
// RULE9 - PLL fifth output feeds only its own edge's regional network
// RULE10 - only positive-side pins feed global and regional routes
// RULE11 - differential receivers source global or regional clock routes
// RULE12 - clock-capable camera lanes source global by default, else regional
// RULE13 - oscillator feeds global buffer; core drives global or regional
// RULE14 - control pins reach set, reset and clock-enable fanout network
// RULE15 - sixteen local lines from global, remote core and regional lines
// RULE16 - regional network gives eight local lines top/bottom, four elsewhere
// RULE17 - regions eighty cells tall, local network forty; memory, arithmetic own
// RULE18 - local fabric makes local clocks and drives each cell enable
// RULE19 - top/bottom interface: sixteen clocks, fourteen global, two fabric
// RULE20 - side interface: four clocks, two fabric, rest global or regional
// RULE21 - dynamic mux switch finishes current phase before new source enters
module fcd_top import fcd_pkg::*; #(
  parameter int N_GPIO = 4,
  parameter int N_LVDS = 2,
  parameter int N_MIPI = 2,
  parameter int N_PLL = 4,
  parameter int N_CORE = 24,
  parameter int N_FAB = 4,
  localparam int SW = `FCD_SEL_W,
  localparam int NRC = `FCD_N_CREG * 2 * `FCD_REG_PER_HALF,
  localparam int NTB = 2 * `FCD_REG_TB,
  localparam int NLN = `FCD_N_CREG * `FCD_REGION_ROWS / `FCD_LOCAL_ROWS,
  localparam int NLR = `FCD_N_CREG * 2,
  localparam int NCELL = `FCD_N_CREG * `FCD_REGION_ROWS,
  localparam int NPIN = N_GPIO + N_LVDS + N_MIPI + N_PLL * `FCD_PLL_OUTS + 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [N_GPIO-1:0] gpio_p_in,
  input wire logic [N_LVDS-1:0] lvds_rx_in,
  input wire logic [N_MIPI-1:0] mipi_lane_in,
  input wire logic [N_PLL*`FCD_PLL_OUTS-1:0] pll_clk_in,
  input wire logic osc_in,
  input wire logic [N_MIPI-1:0] mipi_clk_capable,
  input wire logic [N_MIPI-1:0] mipi_regional,
  input wire logic [N_LVDS-1:0] lvds_regional,
  input wire logic [N_CORE-1:0] core_sig,
  input wire logic [`FCD_N_GLOBAL*SW-1:0] glb_src_cfg,
  input wire logic [`FCD_N_GLOBAL-1:0] glb_en,
  input wire logic [`FCD_N_DYN*`FCD_DYN_INPUTS*SW-1:0] dyn_in_cfg,
  input wire logic [`FCD_N_DYN*`FCD_DYN_SEL_W-1:0] dyn_sel,
  input wire logic [NRC*SW-1:0] reg_src_cfg,
  input wire logic [NRC-1:0] reg_en,
  input wire logic [NTB*SW-1:0] tb_src_cfg,
  input wire logic [NTB-1:0] tb_en,
  input wire logic [NLN*`FCD_N_LOCAL*SW-1:0] loc_src_cfg,
  input wire logic [`FCD_REMOTE_CORE-1:0] remote_core,
  input wire logic [`FCD_N_CREG*N_FAB-1:0] loc_fab,
  input wire logic [`FCD_N_CREG*2*SW-1:0] blk_src_cfg,
  input wire logic [2*`FCD_TB_GLOBAL*SW-1:0] tbi_src_cfg,
  input wire logic [2*`FCD_TB_FABRIC-1:0] tbi_fab,
  input wire logic [NLR*(`FCD_LR_CLKS-`FCD_LR_FABRIC)*SW-1:0] lri_src_cfg,
  input wire logic [NLR*`FCD_LR_FABRIC-1:0] lri_fab,
  input wire logic [`FCD_CTL_N*`FCD_CTL_SEL_W-1:0] ctl_sel,
  input wire logic [NCELL-1:0] cell_ce_in,
  output logic [`FCD_N_GLOBAL-1:0] glb_route_q,
  output logic [NRC-1:0] reg_route_q,
  output logic [NTB-1:0] tb_route_q,
  output logic [NLN*`FCD_N_LOCAL-1:0] loc_net_q,
  output logic [`FCD_N_CREG*2-1:0] blk_clk_q,
  output logic [2*`FCD_TB_CLKS-1:0] tbi_clk_q,
  output logic [NLR*`FCD_LR_CLKS-1:0] lri_clk_q,
  output logic [`FCD_CTL_N-1:0] le_ctrl_q,
  output logic [NCELL-1:0] cell_ce_q
);
  logic rst_m_q;
  logic rst_sync_n;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_s_q;
  logic [N_GPIO-1:0] gpio_s;
  logic [N_LVDS-1:0] lvds_s;
  logic [N_MIPI-1:0] mipi_s;
  logic [N_PLL*`FCD_PLL_OUTS-1:0] pll_s;
  logic osc_s;
  logic [N_LVDS-1:0] lvds_g;
  logic [N_LVDS-1:0] lvds_r;
  logic [N_MIPI-1:0] mipi_g;
  logic [N_MIPI-1:0] mipi_r;
  logic [N_PLL*`FCD_PLL_GLB_OUTS-1:0] pll_g;
  logic [N_PLL-1:0] pll_fifth_output;
  logic [`FCD_N_DYN-1:0] dyn_q;
  logic [`FCD_N_GLOBAL-1:0] global_buffer_block_raw;
  fcd_pool_t glb_pool;
  fcd_pool_t reg_pool;

  // reset leaves through two flops so release is clean on clk_sys
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_sync_n <= rst_m_q;
    end
  end

  // pin and PLL levels are foreign to clk_sys; only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= {osc_in, pll_clk_in, mipi_lane_in, lvds_rx_in, gpio_p_in};
      pin_s_q <= pin_m_q;
    end
  end

  assign {osc_s, pll_s, mipi_s, lvds_s, gpio_s} = pin_s_q;

  // regional use steals the lane from the global pool
  assign lvds_g = lvds_s & ~lvds_regional; // see RULE11
  assign lvds_r = lvds_s & lvds_regional; // see RULE11
  assign mipi_g = mipi_s & mipi_clk_capable & ~mipi_regional; // see RULE12
  assign mipi_r = mipi_s & mipi_clk_capable & mipi_regional; // see RULE12

  always_comb begin
    for (int p = 0; p < N_PLL; p++) begin
      for (int o = 0; o < `FCD_PLL_GLB_OUTS; o++) begin
        pll_g[p*`FCD_PLL_GLB_OUTS+o] = pll_s[p*`FCD_PLL_OUTS+o]; // see RULE8
      end
      pll_fifth_output[p] = pll_s[p*`FCD_PLL_OUTS+`FCD_PLL_OUT4]; // see RULE9
    end
  end

  // pool only holds positive-side pins; bits above the sources read zero
  assign glb_pool = fcd_pool_t'({dyn_q, osc_s, pll_g, mipi_g, lvds_g, gpio_s, core_sig}); // see RULE10
  assign reg_pool = fcd_pool_t'({mipi_r, lvds_r, global_buffer_block_raw}); // see RULE7

  genvar g;
  genvar i;

  // dynamic muxes k*2 and k*2+1 sit on side k
  generate
    for (g = 0; g < `FCD_N_DYN; g++) begin : g_dyn
      logic [`FCD_DYN_INPUTS-1:0] dsrc;
      for (i = 0; i < `FCD_DYN_INPUTS; i++) begin : g_in
        assign dsrc[i] = fcd_pick(glb_pool, dyn_in_cfg[(g*`FCD_DYN_INPUTS+i)*SW +: SW]);
      end
      fcd_dynmux #(.N(`FCD_DYN_INPUTS), .SW(`FCD_DYN_SEL_W)) u_dyn (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .src(dsrc),
        .sel(dyn_sel[g*`FCD_DYN_SEL_W +: `FCD_DYN_SEL_W]), // see RULE4
        .out_q(dyn_q[g]) // see RULE3
      );
    end
  endgenerate

  // global buffers: oscillator, core and interface all enter through the pool
  generate
    for (g = 0; g < `FCD_N_GLOBAL; g++) begin : g_glb
      assign global_buffer_block_raw[g] = fcd_pick(glb_pool, glb_src_cfg[g*SW +: SW]); // see RULE13
      fcd_gate u_gate (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .src(global_buffer_block_raw[g]),
        .en(glb_en[g]),
        .out_q(glb_route_q[g]) // see RULE1
      );
    end
  endgenerate

  // core regional lines: region g/8, half (g/4)%2 each with its own selects
  generate
    for (g = 0; g < NRC; g++) begin : g_reg
      fcd_gate u_gate (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .src(fcd_pick(reg_pool, reg_src_cfg[g*SW +: SW])), // see RULE6
        .en(reg_en[g]),
        .out_q(reg_route_q[g]) // see RULE5
      );
    end
  endgenerate

  // edge lines 0..7 top, 8..15 bottom; each sees only its own PLLs' fifth outputs
  generate
    for (g = 0; g < NTB; g++) begin : g_tb
      fcd_pool_t tpool;
      if (g < `FCD_REG_TB) begin : g_top
        assign tpool = fcd_pool_t'({pll_fifth_output[N_PLL/2-1:0], mipi_r, lvds_r, global_buffer_block_raw});
      end else begin : g_bot
        assign tpool = fcd_pool_t'({pll_fifth_output[N_PLL-1:N_PLL/2], mipi_r, lvds_r,
          global_buffer_block_raw});
      end
      fcd_gate u_gate (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .src(fcd_pick(tpool, tb_src_cfg[g*SW +: SW])), // see RULE9
        .en(tb_en[g]),
        .out_q(tb_route_q[g]) // see RULE5
      );
    end
  endgenerate

  // two local networks of 40 rows per region column
  generate
    for (g = 0; g < NLN; g++) begin : g_loc
      localparam int R = g * `FCD_LOCAL_ROWS / `FCD_REGION_ROWS;
      fcd_pool_t lpool;
      assign lpool = fcd_pool_t'({loc_fab[R*N_FAB +: N_FAB],
        reg_route_q[R*2*`FCD_REG_PER_HALF +: `FCD_REG_PER_HALF], remote_core,
        glb_route_q}); // see RULE16
      always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          loc_net_q[g*`FCD_N_LOCAL +: `FCD_N_LOCAL] <= '0;
        end else begin
          for (int k = 0; k < `FCD_N_LOCAL; k++) begin
            loc_net_q[g*`FCD_N_LOCAL+k] <=
              fcd_pick(lpool, loc_src_cfg[(g*`FCD_N_LOCAL+k)*SW +: SW]); // see RULE15
          end
        end
      end
    end
  endgenerate

  // memory and arithmetic columns get a network of their own per region
  generate
    for (g = 0; g < `FCD_N_CREG; g++) begin : g_blk
      fcd_pool_t bpool;
      assign bpool = fcd_pool_t'({loc_fab[g*N_FAB +: N_FAB],
        reg_route_q[g*2*`FCD_REG_PER_HALF +: `FCD_REG_PER_HALF], remote_core,
        glb_route_q}); // see RULE18
      always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          blk_clk_q[g*2 +: 2] <= '0;
        end else begin
          blk_clk_q[g*2] <= fcd_pick(bpool, blk_src_cfg[g*2*SW +: SW]); // see RULE17
          blk_clk_q[g*2+1] <= fcd_pick(bpool, blk_src_cfg[(g*2+1)*SW +: SW]); // see RULE17
        end
      end
    end
  endgenerate

  // edge interface clocks: 14 picked from the pool, last 2 straight from fabric
  generate
    for (g = 0; g < 2; g++) begin : g_tbi
      fcd_pool_t ipool;
      assign ipool = fcd_pool_t'({tb_route_q[g*`FCD_REG_TB +: `FCD_REG_TB], glb_route_q});
      always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          tbi_clk_q[g*`FCD_TB_CLKS +: `FCD_TB_CLKS] <= '0;
        end else begin
          for (int k = 0; k < `FCD_TB_GLOBAL; k++) begin
            tbi_clk_q[g*`FCD_TB_CLKS+k] <=
              fcd_pick(ipool, tbi_src_cfg[(g*`FCD_TB_GLOBAL+k)*SW +: SW]); // see RULE19
          end
          tbi_clk_q[g*`FCD_TB_CLKS+`FCD_TB_GLOBAL +: `FCD_TB_FABRIC] <=
            tbi_fab[g*`FCD_TB_FABRIC +: `FCD_TB_FABRIC]; // see RULE19
        end
      end
    end
  endgenerate

  // side interfaces: index g = region*2 + side, side 0 left
  generate
    for (g = 0; g < NLR; g++) begin : g_lri
      localparam int NS = `FCD_LR_CLKS - `FCD_LR_FABRIC;
      fcd_pool_t spool;
      assign spool = fcd_pool_t'({reg_route_q[g*`FCD_REG_PER_HALF +: `FCD_REG_PER_HALF],
        glb_route_q});
      always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          lri_clk_q[g*`FCD_LR_CLKS +: `FCD_LR_CLKS] <= '0;
        end else begin
          lri_clk_q[g*`FCD_LR_CLKS +: `FCD_LR_FABRIC] <=
            lri_fab[g*`FCD_LR_FABRIC +: `FCD_LR_FABRIC]; // see RULE20
          for (int k = 0; k < NS; k++) begin
            lri_clk_q[g*`FCD_LR_CLKS+`FCD_LR_FABRIC+k] <=
              fcd_pick(spool, lri_src_cfg[(g*NS+k)*SW +: SW]); // see RULE20
          end
        end
      end
    end
  endgenerate

  // any global line can act as set, reset or clock enable fanout
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      le_ctrl_q <= '0;
    end else begin
      for (int c = 0; c < `FCD_CTL_N; c++) begin
        le_ctrl_q[c] <= glb_route_q[ctl_sel[c*`FCD_CTL_SEL_W +: `FCD_CTL_SEL_W]]; // see RULE14
      end
    end
  end

  // per-cell enable is fabric-driven so every cell may differ
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cell_ce_q <= '0;
    end else begin
      cell_ce_q <= cell_ce_in; // see RULE18
    end
  end

  AST_CELL_CE_LAT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see RULE18
    rst_sync_n |=> cell_ce_q == $past(cell_ce_in))
    else $error("cell enable did not follow fabric");
  AST_MIPI_QUAL: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // see RULE12
    !mipi_clk_capable[1] |-> (!mipi_g[1] && !mipi_r[1]))
    else $error("non clock lane reached a clock route");
endmodule : fcd_top
`default_nettype wire

//--- dv/fcd_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_src_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [28:0] lvl,
  output logic [3:0] gpio_p,
  output logic [1:0] lvds,
  output logic [1:0] mipi,
  output logic [19:0] pll,
  output logic osc
);
  // slow mode lags every source by five cycles, as a late pll lock would
  logic [28:0] lag_q [0:5];
  // launched on the rising edge so the bench's falling-edge writes never race it
  always_ff @(posedge clk_sys) begin
    lag_q[0] <= lvl;
    for (int i = 1; i < 6; i++) begin
      lag_q[i] <= lag_q[i-1];
    end
  end
  // only the positive-side pin of each pair is modelled as a source
  assign {osc, pll, mipi, lvds, gpio_p} = slow ? lag_q[5] : lag_q[0];
endmodule : fcd_src_model
`default_nettype wire

//--- dv/fabric_clock_distribution_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, exp, got); \
  end \
end
module fabric_clock_distribution_tb import fcd_pkg::*;;
  logic clk_sys, rst_n, slow, osc_in;
  logic [28:0] pin_lvl;
  logic [3:0] gpio_p_in;
  logic [1:0] lvds_rx_in, mipi_lane_in, mipi_clk_capable, mipi_regional, lvds_regional;
  logic [19:0] pll_clk_in;
  logic [23:0] core_sig;
  logic [191:0] glb_src_cfg, reg_src_cfg;
  logic [31:0] glb_en, reg_en, tbi_clk_q, lri_clk_q, glb_route_q, reg_route_q;
  logic [191:0] dyn_in_cfg;
  logic [15:0] dyn_sel, tb_en, remote_core, loc_fab, lri_fab, tb_route_q;
  logic [95:0] tb_src_cfg, lri_src_cfg;
  logic [767:0] loc_src_cfg;
  logic [47:0] blk_src_cfg;
  logic [167:0] tbi_src_cfg;
  logic [3:0] tbi_fab;
  logic [14:0] ctl_sel;
  logic [319:0] cell_ce_in, cell_ce_q;
  logic [127:0] loc_net_q;
  logic [7:0] blk_clk_q;
  logic [2:0] le_ctrl_q;
  int n_errors = 0;
  int comparisons = 0;

  fcd_src_model src (.clk_sys(clk_sys), .slow(slow), .lvl(pin_lvl), .gpio_p(gpio_p_in),
    .lvds(lvds_rx_in), .mipi(mipi_lane_in), .pll(pll_clk_in), .osc(osc_in));

  fcd_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .gpio_p_in(gpio_p_in),
    .lvds_rx_in(lvds_rx_in), .mipi_lane_in(mipi_lane_in), .pll_clk_in(pll_clk_in),
    .osc_in(osc_in), .mipi_clk_capable(mipi_clk_capable), .mipi_regional(mipi_regional),
    .lvds_regional(lvds_regional), .core_sig(core_sig), .glb_src_cfg(glb_src_cfg),
    .glb_en(glb_en), .dyn_in_cfg(dyn_in_cfg), .dyn_sel(dyn_sel), .reg_src_cfg(reg_src_cfg),
    .reg_en(reg_en), .tb_src_cfg(tb_src_cfg), .tb_en(tb_en), .loc_src_cfg(loc_src_cfg),
    .remote_core(remote_core), .loc_fab(loc_fab), .blk_src_cfg(blk_src_cfg),
    .tbi_src_cfg(tbi_src_cfg), .tbi_fab(tbi_fab), .lri_src_cfg(lri_src_cfg),
    .lri_fab(lri_fab), .ctl_sel(ctl_sel), .cell_ce_in(cell_ce_in),
    .glb_route_q(glb_route_q), .reg_route_q(reg_route_q), .tb_route_q(tb_route_q),
    .loc_net_q(loc_net_q), .blk_clk_q(blk_clk_q), .tbi_clk_q(tbi_clk_q),
    .lri_clk_q(lri_clk_q), .le_ctrl_q(le_ctrl_q), .cell_ce_q(cell_ce_q));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic t_global;
    for (int l = 0; l < 32; l++) glb_src_cfg[l*6+:6] = 6'(l % 24);
    glb_en = '1;
    cyc(2);
    core_sig = '1;
    cyc(3);
    `CHECK_EQ("glb all high", 32'hFFFFFFFF, glb_route_q)
    // enable drop while the source is high must not cut the pulse
    glb_en[3] = 1'b0;
    cyc(3);
    `CHECK_EQ("glb drop held", 1'b1, glb_route_q[3])
    core_sig = '0;
    cyc(3);
    `CHECK_EQ("glb all low", 32'h0, glb_route_q)
    core_sig = '1;
    cyc(3);
    `CHECK_EQ("glb gated", 32'hFFFFFFF7, glb_route_q)
    core_sig = '0;
    cyc(2);
    glb_en = '1;
    cyc(3);
    $display("test global done");
  endtask : t_global

  task automatic t_dyn;
    for (int k = 0; k < 8; k++) begin
      glb_src_cfg[k*6+:6] = 6'(49 + k);
      dyn_in_cfg[k*24+:12] = {6'h01, 6'h00};
    end
    core_sig[0] = 1'b1;
    cyc(8);
    `CHECK_EQ("dyn first source", 8'hFF, glb_route_q[7:0])
    core_sig[1] = 1'b1;
    dyn_sel = {8{2'h1}};
    cyc(6);
    `CHECK_EQ("dyn drain", 8'hFF, glb_route_q[7:0])
    core_sig[0] = 1'b0;
    cyc(6);
    `CHECK_EQ("dyn arm low", 8'h00, glb_route_q[7:0])
    core_sig[1] = 1'b0;
    cyc(3);
    core_sig[1] = 1'b1;
    cyc(6);
    `CHECK_EQ("dyn new source", 8'hFF, glb_route_q[7:0])
    core_sig[1:0] = 2'h1;
    cyc(6);
    `CHECK_EQ("dyn old ignored", 8'h00, glb_route_q[7:0])
    core_sig = '0;
    dyn_sel = '0;
    cyc(6);
    glb_src_cfg = '1;
    $display("test dynamic mux done");
  endtask : t_dyn

  task automatic t_pins;
    for (int l = 0; l < 25; l++) glb_src_cfg[l*6+:6] = 6'(24 + l);
    reg_src_cfg[0+:6] = 6'h21;
    reg_src_cfg[6+:6] = 6'h22;
    mipi_regional = 2'h1;
    tb_src_cfg[0+:6] = 6'h24;
    tb_src_cfg[48+:6] = 6'h24;
    reg_en = '1;
    tb_en = '1;
    cyc(2);
    // every pin high except the fifth output of the first bottom pll
    pin_lvl = 29'h1FFFFFFF & ~(29'h1 << 22);
    cyc(10);
    `CHECK_EQ("pin globals", 25'h1FFFF1F, glb_route_q[24:0])
    `CHECK_EQ("lvds regional", 1'b1, reg_route_q[0])
    `CHECK_EQ("mipi regional", 2'h3, reg_route_q[1:0])
    `CHECK_EQ("pll5 edges", 2'h1, {tb_route_q[8], tb_route_q[0]})
    slow = 1'b1;
    pin_lvl = '1;
    cyc(3);
    `CHECK_EQ("pll5 slow", 1'b0, tb_route_q[8])
    cyc(10);
    `CHECK_EQ("pll5 bottom", 1'b1, tb_route_q[8])
    slow = 1'b0;
    pin_lvl = '0;
    cyc(12);
    `CHECK_EQ("pins low", 25'h0, glb_route_q[24:0])
    glb_src_cfg = '1;
    $display("test pin sources done");
  endtask : t_pins

  task automatic t_local;
    glb_src_cfg[11:0] = {6'h01, 6'h00};
    reg_src_cfg[0+:6] = 6'h00;
    reg_src_cfg[24+:6] = 6'h01;
    reg_src_cfg[144+:6] = 6'h01;
    reg_src_cfg[72+:6] = 6'h01;
    loc_src_cfg[17:0] = {6'h30, 6'h34, 6'h23};
    loc_src_cfg[(126*6)+:12] = {6'h37, 6'h30};
    blk_src_cfg[42+:6] = 6'h01;
    cyc(2);
    core_sig[0] = 1'b1;
    remote_core[3] = 1'b1;
    loc_fab[15] = 1'b1;
    cyc(6);
    `CHECK_EQ("reg halves", 3'h1, {reg_route_q[24], reg_route_q[4], reg_route_q[0]})
    `CHECK_EQ("local net 0", 3'h5, loc_net_q[2:0])
    `CHECK_EQ("local net 7", 2'h2, loc_net_q[127:126])
    `CHECK_EQ("arith clock off", 1'b0, blk_clk_q[7])
    core_sig[1] = 1'b1;
    cyc(6);
    `CHECK_EQ("reg right", 3'h7, {reg_route_q[24], reg_route_q[4], reg_route_q[0]})
    `CHECK_EQ("local net 7 reg", 2'h3, loc_net_q[127:126])
    `CHECK_EQ("arith clock on", 1'b1, blk_clk_q[7])
    $display("test regional and local done");
  endtask : t_local

  task automatic t_iface;
    tbi_src_cfg[78+:6] = 6'h01;
    tbi_fab = 4'h9;
    lri_src_cfg[36+:12] = {6'h20, 6'h01};
    lri_fab[7:6] = 2'h2;
    cyc(6);
    `CHECK_EQ("edge iface", 3'h7, {tbi_clk_q[31], tbi_clk_q[14:13]})
    `CHECK_EQ("edge fab off", 1'b0, tbi_clk_q[15])
    `CHECK_EQ("side iface", 4'hE, lri_clk_q[15:12])
    $display("test interface clocks done");
  endtask : t_iface

  task automatic t_cells;
    ctl_sel = {5'h01, 5'h00, 5'h01};
    core_sig[0] = 1'b0;
    cell_ce_in = {10{32'hA5C30F96}};
    cyc(1);
    `CHECK_EQ("cell enables", {10{32'hA5C30F96}}, cell_ce_q)
    cyc(4);
    `CHECK_EQ("control lines", 3'h5, le_ctrl_q)
    $display("test control and cells done");
  endtask : t_cells

  initial begin
    rst_n = 1'b0;
    slow = 1'b0;
    pin_lvl = '0;
    mipi_clk_capable = 2'h1;
    mipi_regional = 2'h0;
    lvds_regional = 2'h2;
    core_sig = '0;
    {glb_src_cfg, reg_src_cfg, tb_src_cfg, dyn_in_cfg} = '1;
    {loc_src_cfg, blk_src_cfg, tbi_src_cfg, lri_src_cfg} = '1;
    {glb_en, reg_en, tb_en, dyn_sel, remote_core, loc_fab, lri_fab, tbi_fab} = '0;
    ctl_sel = '1;
    cell_ce_in = '1;
    cyc(8);
    `CHECK_EQ("reset outputs", 0, {glb_route_q, reg_route_q, cell_ce_q})
    rst_n = 1'b1;
    cyc(5);
    t_global;
    t_dyn;
    t_pins;
    t_local;
    t_iface;
    t_cells;
    final_report;
  end

  // whole run is about 135 cycles; allow over twenty times that
  initial begin
    #30000;
    n_errors++;
    final_report;
  end
endmodule : fabric_clock_distribution_tb
`default_nettype wire
